// *** src/lms_top.sv ***
// Functional notes
// - Three mode pins alone choose the circuit's operating state.
// - Detector output drives only while read enable is high.
// - Ringing reports ring-trip; other active states report loop current.
// - Byte 20 gives open-circuit: both amplifiers high impedance, detector off.
// - Byte 22 gives ringing: relay on, amplifiers off, transmission inhibited.
// - Byte 60 gives normal state; byte 62 gives stand-by; detector on.
// - Stand-by limits loop current to 1.5 times detector threshold.
// - Bytes A0, E0, C2 give tip-open, reversal, reversal stand-by.
// - Dual-channel bytes 44, CC, 66, EE, 55, 77, FF give same seven states.
// - Channel A commands 43, 53, 4B, 5B, 47, 4F, 5F give seven states.
// - First divider position halves the 512 kHz codec clock.
// - Second divider position divides 4096 kHz by sixteen.
// - Driver first position passes divided clock; otherwise driver is off.
module lms_top
	import lms_pkg::*;
(
	input  wire logic    clock,
	input  wire logic    sys_rst,
	input  wire logic    mode_control_bit_1,
	input  wire logic    mode_control_bit_2,
	input  wire logic    mode_control_bit_3,
	input  wire logic    detector_read_enable,
	input  wire logic    loop_current_detected,
	input  wire logic    ring_trip_detected,
	input  wire logic    codec_clock,
	input  wire logic    divider_ratio_select,
	input  wire logic    clock_driver_select,
	output lms_state_type line_state,
	output logic         tip_line_amplifier_hiz,
	output logic         ring_line_amplifier_hiz,
	output logic         ring_relay_drive,
	output logic         transmission_enable,
	output logic         loop_detector_active,
	output logic         polarity_reversed,
	output logic         standby_current_limit,
	output logic         detector_output_n,
	output logic         detector_output_oe_n,
	output logic         line_clock,
	output logic         line_clock_oe_n
);

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------

	logic [SYNC_WIDTH-1:0] pins_raw;
	logic [SYNC_WIDTH-1:0] pins_sync;
	logic [2:0]            mode_sync;
	logic                  enable_sync;
	logic                  loop_sync;
	logic                  trip_sync;
	logic                  codec_sync;
	logic                  ratio_sync;
	logic                  driver_sync;

	// All pins are gathered into one synchroniser bank.
	assign pins_raw = {mode_control_bit_3, mode_control_bit_2, mode_control_bit_1,
		detector_read_enable, loop_current_detected, ring_trip_detected,
		codec_clock, divider_ratio_select, clock_driver_select};

	lms_sync #(
		.WIDTH (SYNC_WIDTH)
	) u_sync (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.async_in (pins_raw),
		.sync_out (pins_sync)
	);

	// The synchronised bank is split back into named levels.
	assign mode_sync   = pins_sync[8:6];
	assign enable_sync = pins_sync[5];
	assign loop_sync   = pins_sync[4];
	assign trip_sync   = pins_sync[3];
	assign codec_sync  = pins_sync[2];
	assign ratio_sync  = pins_sync[1];
	assign driver_sync = pins_sync[0];

	// ------------------------------------------------------------
	// Operating state
	// ------------------------------------------------------------

	lms_state_type next_state;

	// The mode pins alone select the state; the byte tables of every
	// codec variant reduce to these same three-bit codes.
	assign next_state = lms_decode_mode(mode_sync);

	// The state register follows the decoded mode pins.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			line_state <= LMS_ST_OPEN;
		end else begin
			line_state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Line drive controls
	// ------------------------------------------------------------

	// Each state sets amplifiers, relay, transmission and detector controls.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			tip_line_amplifier_hiz  <= 1'b1;
			ring_line_amplifier_hiz <= 1'b1;
			ring_relay_drive        <= 1'b0;
			transmission_enable     <= 1'b0;
			loop_detector_active    <= 1'b0;
			polarity_reversed       <= 1'b0;
			standby_current_limit   <= 1'b0;
		end else begin
			case (next_state)
				LMS_ST_OPEN: begin
					tip_line_amplifier_hiz  <= 1'b1;
					ring_line_amplifier_hiz <= 1'b1;
					ring_relay_drive        <= 1'b0;
					transmission_enable     <= 1'b0;
					loop_detector_active    <= 1'b0;
					polarity_reversed       <= 1'b0;
					standby_current_limit   <= 1'b0;
				end
				LMS_ST_RINGING: begin
					tip_line_amplifier_hiz  <= 1'b1;
					ring_line_amplifier_hiz <= 1'b1;
					ring_relay_drive        <= 1'b1;
					transmission_enable     <= 1'b0;
					loop_detector_active    <= 1'b0;
					polarity_reversed       <= 1'b0;
					standby_current_limit   <= 1'b0;
				end
				LMS_ST_NORMAL: begin
					tip_line_amplifier_hiz  <= 1'b0;
					ring_line_amplifier_hiz <= 1'b0;
					ring_relay_drive        <= 1'b0;
					transmission_enable     <= 1'b1;
					loop_detector_active    <= 1'b1;
					polarity_reversed       <= 1'b0;
					standby_current_limit   <= 1'b0;
				end
				LMS_ST_STANDBY: begin
					tip_line_amplifier_hiz  <= 1'b0;
					ring_line_amplifier_hiz <= 1'b0;
					ring_relay_drive        <= 1'b0;
					transmission_enable     <= 1'b0;
					loop_detector_active    <= 1'b1;
					polarity_reversed       <= 1'b0;
					standby_current_limit   <= 1'b1;
				end
				LMS_ST_TIP_OPEN: begin
					tip_line_amplifier_hiz  <= 1'b1;
					ring_line_amplifier_hiz <= 1'b0;
					ring_relay_drive        <= 1'b0;
					transmission_enable     <= 1'b0;
					loop_detector_active    <= 1'b1;
					polarity_reversed       <= 1'b0;
					standby_current_limit   <= 1'b0;
				end
				LMS_ST_REVERSAL: begin
					tip_line_amplifier_hiz  <= 1'b0;
					ring_line_amplifier_hiz <= 1'b0;
					ring_relay_drive        <= 1'b0;
					transmission_enable     <= 1'b1;
					loop_detector_active    <= 1'b1;
					polarity_reversed       <= 1'b1;
					standby_current_limit   <= 1'b0;
				end
				LMS_ST_REV_STANDBY: begin
					tip_line_amplifier_hiz  <= 1'b0;
					ring_line_amplifier_hiz <= 1'b0;
					ring_relay_drive        <= 1'b0;
					transmission_enable     <= 1'b0;
					loop_detector_active    <= 1'b1;
					polarity_reversed       <= 1'b1;
					standby_current_limit   <= 1'b1;
				end
				default: begin
					tip_line_amplifier_hiz  <= 1'b1;
					ring_line_amplifier_hiz <= 1'b1;
					ring_relay_drive        <= 1'b0;
					transmission_enable     <= 1'b0;
					loop_detector_active    <= 1'b0;
					polarity_reversed       <= 1'b0;
					standby_current_limit   <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Detector output
	// ------------------------------------------------------------

	logic next_detect;

	// Ringing routes the ring-trip monitor; open circuit reports nothing.
	always_comb begin
		case (next_state)
			LMS_ST_RINGING: next_detect = trip_sync;
			LMS_ST_OPEN:    next_detect = 1'b0;
			default:        next_detect = loop_sync;
		endcase
	end

	// The active-low detector pin drives only while read enable is high.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			detector_output_n    <= 1'b1;
			detector_output_oe_n <= 1'b1;
		end else begin
			detector_output_n    <= !next_detect;
			detector_output_oe_n <= !enable_sync;
		end
	end

	// ------------------------------------------------------------
	// Line circuit clock
	// ------------------------------------------------------------

	lms_clk_div u_clk_div (
		.clock                (clock),
		.sys_rst              (sys_rst),
		.codec_clock_level    (codec_sync),
		.divider_ratio_select (ratio_sync),
		.clock_driver_select  (driver_sync),
		.line_clock           (line_clock),
		.line_clock_oe_n      (line_clock_oe_n)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------

	AST_DET_DISABLED: assert property (@(posedge clock) disable iff (sys_rst)
		!enable_sync |=> detector_output_oe_n)
		else $error("Detector driven while read enable low.");

	AST_DET_ENABLED: assert property (@(posedge clock) disable iff (sys_rst)
		enable_sync |=> !detector_output_oe_n)
		else $error("Detector not driven while read enable high.");

	AST_RING_TRIP_ROUTED: assert property (@(posedge clock) disable iff (sys_rst)
		(mode_sync == MODE_RINGING) |=> detector_output_n == !$past(trip_sync))
		else $error("Ring-trip status not on detector in ringing.");

	AST_LOOP_ROUTED: assert property (@(posedge clock) disable iff (sys_rst)
		(mode_sync == MODE_NORMAL) |=> detector_output_n == !$past(loop_sync))
		else $error("Loop status not on detector in normal state.");

	AST_OPEN_STATE: assert property (@(posedge clock) disable iff (sys_rst)
		(mode_sync == MODE_OPEN) |=> (line_state == LMS_ST_OPEN && tip_line_amplifier_hiz
		&& ring_line_amplifier_hiz && !loop_detector_active))
		else $error("Open-circuit state not applied.");

	AST_RINGING_STATE: assert property (@(posedge clock) disable iff (sys_rst)
		(mode_sync == MODE_RINGING) |=> (ring_relay_drive && !transmission_enable
		&& tip_line_amplifier_hiz && ring_line_amplifier_hiz))
		else $error("Ringing state controls wrong.");

	AST_NORMAL_STATE: assert property (@(posedge clock) disable iff (sys_rst)
		(mode_sync == MODE_NORMAL) |=> (line_state == LMS_ST_NORMAL
		&& transmission_enable && loop_detector_active))
		else $error("Normal state controls wrong.");

	AST_STANDBY_LIMIT: assert property (@(posedge clock) disable iff (sys_rst)
		(mode_sync == MODE_STANDBY || mode_sync == MODE_REV_STANDBY)
		|=> standby_current_limit && loop_detector_active)
		else $error("Stand-by current limit not applied.");

	AST_REVERSAL_STATE: assert property (@(posedge clock) disable iff (sys_rst)
		(mode_sync == MODE_REVERSAL) |=> (polarity_reversed && transmission_enable
		&& !standby_current_limit))
		else $error("Polarity reversal controls wrong.");

	AST_TIP_OPEN_STATE: assert property (@(posedge clock) disable iff (sys_rst)
		(mode_sync == MODE_TIP_OPEN) |=> (line_state == LMS_ST_TIP_OPEN
		&& tip_line_amplifier_hiz && !ring_line_amplifier_hiz && loop_detector_active))
		else $error("Tip open-circuit controls wrong.");

	AST_REV_STANDBY_STATE: assert property (@(posedge clock) disable iff (sys_rst)
		(mode_sync == MODE_REV_STANDBY) |=> (line_state == LMS_ST_REV_STANDBY
		&& polarity_reversed && standby_current_limit && !transmission_enable))
		else $error("Reversal stand-by controls wrong.");

	AST_STANDBY_STATE: assert property (@(posedge clock) disable iff (sys_rst)
		(mode_sync == MODE_STANDBY) |=> (line_state == LMS_ST_STANDBY
		&& !transmission_enable && !polarity_reversed))
		else $error("Stand-by state controls wrong.");

	AST_RELAY_ONLY_RINGING: assert property (@(posedge clock) disable iff (sys_rst)
		(mode_sync != MODE_RINGING) |=> !ring_relay_drive)
		else $error("Ring relay driven outside ringing.");

	AST_OPEN_NO_DETECT: assert property (@(posedge clock) disable iff (sys_rst)
		(mode_sync == MODE_OPEN) |=> detector_output_n)
		else $error("Detection reported in open-circuit state.");

endmodule

// *** src/lms_pkg.sv ***
package lms_pkg;

	// ------------------------------------------------------------
	// Operating states of the line interface circuit.
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		LMS_ST_OPEN,
		LMS_ST_RINGING,
		LMS_ST_NORMAL,
		LMS_ST_STANDBY,
		LMS_ST_TIP_OPEN,
		LMS_ST_REVERSAL,
		LMS_ST_REV_STANDBY
	} lms_state_type;

	// ------------------------------------------------------------
	// Mode pin codes, ordered {bit 3, bit 2, bit 1}.
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_OPEN        = 3'h0;
	localparam logic [2:0] MODE_RINGING     = 3'h1;
	localparam logic [2:0] MODE_NORMAL      = 3'h2;
	localparam logic [2:0] MODE_STANDBY     = 3'h3;
	localparam logic [2:0] MODE_TIP_OPEN    = 3'h4;
	localparam logic [2:0] MODE_REVERSAL    = 3'h6;
	localparam logic [2:0] MODE_REV_STANDBY = 3'h7;

	// ------------------------------------------------------------
	// Signaling and command bytes that produce the mode pin codes.
	// ------------------------------------------------------------
	localparam logic [7:0] SIG_OPEN        = 8'h20;
	localparam logic [7:0] SIG_RINGING     = 8'h22;
	localparam logic [7:0] SIG_NORMAL      = 8'h60;
	localparam logic [7:0] SIG_STANDBY     = 8'h62;
	localparam logic [7:0] SIG_TIP_OPEN    = 8'hA0;
	localparam logic [7:0] SIG_REVERSAL    = 8'hE0;
	localparam logic [7:0] SIG_REV_STANDBY = 8'hC2;
	localparam logic [7:0] DUAL_OPEN        = 8'h44;
	localparam logic [7:0] DUAL_RINGING     = 8'hCC;
	localparam logic [7:0] DUAL_NORMAL      = 8'h66;
	localparam logic [7:0] DUAL_STANDBY     = 8'hEE;
	localparam logic [7:0] DUAL_TIP_OPEN    = 8'h55;
	localparam logic [7:0] DUAL_REVERSAL    = 8'h77;
	localparam logic [7:0] DUAL_REV_STANDBY = 8'hFF;
	localparam logic [7:0] CMD_OPEN         = 8'h43;
	localparam logic [7:0] CMD_RINGING      = 8'h53;
	localparam logic [7:0] CMD_NORMAL       = 8'h4B;
	localparam logic [7:0] CMD_STANDBY      = 8'h5B;
	localparam logic [7:0] CMD_TIP_OPEN     = 8'h47;
	localparam logic [7:0] CMD_REVERSAL     = 8'h4F;
	localparam logic [7:0] CMD_REV_STANDBY  = 8'h5F;
	localparam logic [7:0] CMD_CHANNEL_B    = 8'h80;

	// ------------------------------------------------------------
	// Stand-by current limit, in tenths of the detector threshold.
	// ------------------------------------------------------------
	localparam int STANDBY_LIMIT_TENTHS = 15;

	// ------------------------------------------------------------
	// Clock divider figures.
	// ------------------------------------------------------------
	localparam int CODEC_CLK_LOW_KHZ  = 512;
	localparam int CODEC_CLK_HIGH_KHZ = 4096;
	localparam int LINE_CLK_KHZ       = 256;
	localparam int DIV_RATIO_LOW      = CODEC_CLK_LOW_KHZ / LINE_CLK_KHZ;
	localparam int DIV_RATIO_HIGH     = CODEC_CLK_HIGH_KHZ / LINE_CLK_KHZ;
	localparam logic [2:0] DIV_HALF_LOW  = 3'(DIV_RATIO_LOW / 2 - 1);
	localparam logic [2:0] DIV_HALF_HIGH = 3'(DIV_RATIO_HIGH / 2 - 1);

	// ------------------------------------------------------------
	// Synchroniser width: mode bits, enable, two detectors, codec
	// clock and two selects.
	// ------------------------------------------------------------
	localparam int SYNC_WIDTH = 9;

	// Maps the three mode pins to an operating state.
	function automatic lms_state_type lms_decode_mode(input logic [2:0] code);
		lms_state_type st;
		st = LMS_ST_OPEN;
		case (code)
			MODE_OPEN:        st = LMS_ST_OPEN;
			MODE_RINGING:     st = LMS_ST_RINGING;
			MODE_NORMAL:      st = LMS_ST_NORMAL;
			MODE_STANDBY:     st = LMS_ST_STANDBY;
			MODE_TIP_OPEN:    st = LMS_ST_TIP_OPEN;
			MODE_REVERSAL:    st = LMS_ST_REVERSAL;
			MODE_REV_STANDBY: st = LMS_ST_REV_STANDBY;
			default:          st = LMS_ST_OPEN;
		endcase
		return st;
	endfunction

endpackage

// *** src/lms_sync.sv ***
module lms_sync
	import lms_pkg::*;
#(
	parameter int WIDTH = SYNC_WIDTH
) (
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	// Two flip-flops bring pin levels into the clock domain.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

// *** src/lms_clk_div.sv ***
module lms_clk_div
	import lms_pkg::*;
(
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic codec_clock_level,
	input  wire logic divider_ratio_select,
	input  wire logic clock_driver_select,
	output logic      line_clock,
	output logic      line_clock_oe_n
);

	logic       codec_prev;
	logic       codec_rise;
	logic [2:0] count;
	logic [2:0] half_limit;

	assign codec_rise = codec_clock_level && !codec_prev;
	assign half_limit = divider_ratio_select ? DIV_HALF_HIGH : DIV_HALF_LOW;

	// Rising edges of the codec clock toggle the line clock every half ratio.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			codec_prev <= 1'b0;
			count      <= 3'h0;
			line_clock <= 1'b0;
		end else begin
			codec_prev <= codec_clock_level;
			if (codec_rise) begin
				if (count >= half_limit) begin
					count      <= 3'h0;
					line_clock <= !line_clock;
				end else begin
					count <= count + 3'h1;
				end
			end
		end
	end

	// The clock driver is on only in its first position.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			line_clock_oe_n <= 1'b1;
		end else begin
			line_clock_oe_n <= clock_driver_select;
		end
	end

	AST_DIV_DRIVER_OFF: assert property (@(posedge clock) disable iff (sys_rst)
		clock_driver_select |=> line_clock_oe_n)
		else $error("Line clock driver not off in second position.");

	AST_DIV_BY_TWO: assert property (@(posedge clock) disable iff (sys_rst)
		(codec_rise && !divider_ratio_select && count == 3'h0) |=> line_clock != $past(line_clock))
		else $error("Low ratio did not toggle on each codec edge.");

	AST_DIV_BY_SIXTEEN: assert property (@(posedge clock) disable iff (sys_rst)
		(codec_rise && divider_ratio_select && count < 3'h7) |=> line_clock == $past(line_clock))
		else $error("High ratio toggled before eight codec edges.");

endmodule

// *** verif/lms_codec_model.sv ***
// ------------------------------------------------------------
// Codec side: turns control bytes into mode pins and a codec clock.
// ------------------------------------------------------------
module lms_codec_model (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic [1:0]  byte_format,
	input  wire logic [7:0]  control_byte,
	input  wire logic        channel_b,
	input  wire logic [31:0] codec_khz,
	output logic             mode_control_bit_1,
	output logic             mode_control_bit_2,
	output logic             mode_control_bit_3,
	output logic             detector_read_enable,
	output logic             codec_clock
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [3:0]  pins      = 4'h0;
	logic        clk_level = 1'b0;
	logic [31:0] phase     = 32'h0;

	// Pins are ordered {bit 3, bit 2, bit 1, read enable}.
	assign {mode_control_bit_3, mode_control_bit_2, mode_control_bit_1} = pins[3:1];
	assign detector_read_enable = pins[0];
	assign codec_clock = clk_level;

	// Routes the byte of the chosen format onto the pins; a command for the other channel is ignored.
	always @(posedge clock) begin
		if (sys_rst) begin
			pins <= 4'h0;
		end else begin
			case (byte_format)
				2'h0: pins <= {control_byte[7:6], control_byte[1], control_byte[5]};
				2'h1: pins <= {control_byte[0], control_byte[1], control_byte[3], control_byte[2]};
				default: begin
					if (control_byte[7] == channel_b) begin
						pins <= {control_byte[2], control_byte[3], control_byte[4], control_byte[0]};
					end
				end
			endcase
		end
	end

	// Phase accumulator gives the codec clock at the requested rate on average.
	always @(posedge clock) begin
		if (phase + 32'h2 * codec_khz >= 32'h186A0) begin
			phase <= phase + 32'h2 * codec_khz - 32'h186A0;
			clk_level <= ~clk_level;
		end else begin
			phase <= phase + 32'h2 * codec_khz;
		end
	end
endmodule

// *** verif/line_interface_mode_signaling_tb.sv ***
// ------------------------------------------------------------
// Self-checking bench for the line interface mode logic.
// ------------------------------------------------------------
module line_interface_mode_signaling_tb;
	import lms_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int LINE_NS = 1000000 / 256;
	localparam logic [7:0] SINGLE_TAB [7] = '{8'h20, 8'h22, 8'h60, 8'h62, 8'hA0, 8'hE0, 8'hC2};
	localparam logic [7:0] DUAL_TAB   [7] = '{8'h44, 8'hCC, 8'h66, 8'hEE, 8'h55, 8'h77, 8'hFF};
	localparam logic [7:0] CMD_TAB    [7] = '{8'h43, 8'h53, 8'h4B, 8'h5B, 8'h47, 8'h4F, 8'h5F};
	// Expected {tip hiz, ring hiz, relay, tx, loop det, reversed, limit} and care mask.
	localparam logic [6:0] EXP_TAB    [7] = '{7'h60, 7'h70, 7'h0C, 7'h05, 7'h44, 7'h0E, 7'h07};
	localparam logic [6:0] MASK_TAB   [7] = '{7'h7F, 7'h7A, 7'h7F, 7'h1F, 7'h77, 7'h7F, 7'h1F};

	logic          clock;
	logic          sys_rst;
	logic [1:0]    byte_format;
	logic [7:0]    control_byte;
	logic          channel_b;
	logic [31:0]   codec_khz;
	logic          loop_current_detected;
	logic          ring_trip_detected;
	logic          divider_ratio_select;
	logic          clock_driver_select;
	wire logic     mode_control_bit_1;
	wire logic     mode_control_bit_2;
	wire logic     mode_control_bit_3;
	wire logic     detector_read_enable;
	wire logic     codec_clock;
	lms_state_type line_state;
	logic          tip_line_amplifier_hiz;
	logic          ring_line_amplifier_hiz;
	logic          ring_relay_drive;
	logic          transmission_enable;
	logic          loop_detector_active;
	logic          polarity_reversed;
	logic          standby_current_limit;
	logic          detector_output_n;
	logic          detector_output_oe_n;
	logic          line_clock;
	logic          line_clock_oe_n;
	int            n_errors;
	int            cmp_count;
	int            exp_q [$];
	int            per;
	int            s;
	int            f;

	lms_codec_model codec (
		.clock(clock), .sys_rst(sys_rst), .byte_format(byte_format),
		.control_byte(control_byte), .channel_b(channel_b), .codec_khz(codec_khz),
		.mode_control_bit_1(mode_control_bit_1), .mode_control_bit_2(mode_control_bit_2),
		.mode_control_bit_3(mode_control_bit_3), .detector_read_enable(detector_read_enable),
		.codec_clock(codec_clock)
	);

	lms_top dut (
		.clock(clock), .sys_rst(sys_rst), .mode_control_bit_1(mode_control_bit_1),
		.mode_control_bit_2(mode_control_bit_2), .mode_control_bit_3(mode_control_bit_3),
		.detector_read_enable(detector_read_enable),
		.loop_current_detected(loop_current_detected), .ring_trip_detected(ring_trip_detected),
		.codec_clock(codec_clock), .divider_ratio_select(divider_ratio_select),
		.clock_driver_select(clock_driver_select), .line_state(line_state),
		.tip_line_amplifier_hiz(tip_line_amplifier_hiz),
		.ring_line_amplifier_hiz(ring_line_amplifier_hiz), .ring_relay_drive(ring_relay_drive),
		.transmission_enable(transmission_enable), .loop_detector_active(loop_detector_active),
		.polarity_reversed(polarity_reversed), .standby_current_limit(standby_current_limit),
		.detector_output_n(detector_output_n), .detector_output_oe_n(detector_output_oe_n),
		.line_clock(line_clock), .line_clock_oe_n(line_clock_oe_n)
	);

	// Free-running system clock.
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Prints the counts and the verdict, then stops.
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Compares one value and counts the outcome.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Sends a byte, then compares state, pin outputs and detector with the expected values.
	task automatic apply(input logic [1:0] fmt, input logic [7:0] b, input int st, input logic en);
		logic [6:0] seen;
		logic       detector_output;
		@(posedge clock);
		byte_format <= fmt;
		control_byte <= b;
		loop_current_detected <= 1'($urandom_range(1));
		ring_trip_detected <= 1'($urandom_range(1));
		exp_q.push_back(st);
		repeat (6) @(posedge clock);
		#1;
		st = exp_q.pop_front();
		seen = {tip_line_amplifier_hiz, ring_line_amplifier_hiz, ring_relay_drive,
			transmission_enable, loop_detector_active, polarity_reversed, standby_current_limit};
		check(line_state, st);
		check(seen & MASK_TAB[st], EXP_TAB[st]);
		check(detector_output_oe_n, !en);
		detector_output = (st == 1) ? ring_trip_detected : (st != 0 && loop_current_detected);
		if (en)
			check(detector_output_n, !detector_output);
	endtask

	// Waits, with a bound, for the line clock to reach a level.
	task automatic wait_level(input logic lv);
		for (int n = 0; n < 2000 && line_clock !== lv; n++) begin
			@(posedge clock);
			#1;
		end
		if (line_clock !== lv) begin
			n_errors++;
			$display("FAIL t=%0t line clock stuck", $time);
			complete_run;
		end
	endtask

	// Measures one full line clock period in ns.
	task automatic measure(output int p);
		realtime t0;
		wait_level(1'b0);
		wait_level(1'b1);
		t0 = $realtime;
		wait_level(1'b0);
		wait_level(1'b1);
		p = int'($realtime - t0);
	endtask

	// ------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		byte_format = 2'h0;
		control_byte = 8'h20;
		channel_b = 1'b0;
		codec_khz = 32'h200;
		loop_current_detected = 1'b0;
		ring_trip_detected = 1'b0;
		divider_ratio_select = 1'b0;
		clock_driver_select = 1'b1;
		n_errors = 0;
		cmp_count = 0;
		void'($urandom(32'hd9c5));
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		#1;
		check({line_state, tip_line_amplifier_hiz, ring_line_amplifier_hiz, ring_relay_drive,
			detector_output_oe_n, line_clock, line_clock_oe_n}, 32'h035);
		for (int i = 0; i < 7; i++) begin
			apply(2'h0, SINGLE_TAB[i], i, SINGLE_TAB[i][5]);
			apply(2'h1, DUAL_TAB[i], i, DUAL_TAB[i][2]);
			apply(2'h2, CMD_TAB[i], i, CMD_TAB[i][0]);
		end
		apply(2'h0, 8'h82, 0, 1'b0);
		@(posedge clock);
		channel_b <= 1'b1;
		apply(2'h2, 8'hCB, 2, 1'b1);
		apply(2'h2, 8'h43, 2, 1'b1);
		apply(2'h2, 8'hC3, 0, 1'b1);
		@(posedge clock);
		channel_b <= 1'b0;
		repeat (24) begin
			s = $urandom_range(6);
			f = $urandom_range(2);
			if (f == 0)
				apply(2'h0, SINGLE_TAB[s], s, SINGLE_TAB[s][5]);
			else if (f == 1)
				apply(2'h1, DUAL_TAB[s], s, DUAL_TAB[s][2]);
			else
				apply(2'h2, CMD_TAB[s], s, CMD_TAB[s][0]);
		end
		@(posedge clock);
		clock_driver_select <= 1'b0;
		measure(per);
		check(32'(per > LINE_NS - 40 && per < LINE_NS + 40), 32'h1);
		check(line_clock_oe_n, 1'b0);
		@(posedge clock);
		divider_ratio_select <= 1'b1;
		codec_khz <= 32'h1000;
		measure(per);
		measure(per);
		check(32'(per > LINE_NS - 40 && per < LINE_NS + 40), 32'h1);
		@(posedge clock);
		clock_driver_select <= 1'b1;
		repeat (6) @(posedge clock);
		#1;
		check(line_clock_oe_n, 1'b1);
		complete_run;
	end
endmodule
